// [core/smri_defines.vh]
// Constants of the supply monitor, reset and interrupt block.
`ifndef SMRI_DEFINES_VH
`define SMRI_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SMRI_OFF_CTRL      8'h00
`define SMRI_OFF_STATUS    8'h04
`define SMRI_OFF_IRQ_STAT  8'h08
`define SMRI_OFF_IRQ_MASK  8'h0c

// ****************************************
// Field positions
// ****************************************
`define SMRI_CTRL_IRQ_EN   0
`define SMRI_ST_FLAG       0
`define SMRI_ST_LOW        1
`define SMRI_ST_DELAY      2
`define SMRI_ST_OPT        3
`define SMRI_EV_AUX        0
`define SMRI_EV_SUPPLY     1
`define SMRI_EV_ILLEGAL    2
`define SMRI_EV_W          3

// ****************************************
// Reset values and timing
// ****************************************
`define SMRI_CTRL_RST      1'b0
`define SMRI_EV_RST        3'h0
`define SMRI_DATA_RST      32'h0000_0000
`define SMRI_DLY_SHORT     256
`define SMRI_DLY_LONG      4096
`define SMRI_CNT_W         13

`endif

// [core/smri_top.v]
// Supply monitor wrapper: supply reset, auxiliary warning flag and interrupt, APB registers.
`timescale 1ns/10ps
`include "smri_defines.vh"


module smri_top #(
	parameter DLY_SHORT = `SMRI_DLY_SHORT,
	parameter DLY_LONG  = `SMRI_DLY_LONG
) (
	input  wire        pclk,            // System clock, 100 MHz.
	input  wire        presetn,         // Asynchronous reset, active low.
	input  wire        psel,            // APB select.
	input  wire        penable,         // APB access phase.
	input  wire        pwrite,          // APB write when high.
	input  wire [7:0]  paddr,           // APB byte address.
	input  wire [31:0] pwdata,          // APB write data.
	output reg  [31:0] prdata,          // APB read data.
	output reg         pready,          // APB ready.
	output reg         pslverr,         // APB error on unmapped address.
	input  wire        supply_low,      // Low-voltage comparator, high when supply is low.
	input  wire        aux_cmp,         // Auxiliary comparator, high while warning is on.
	input  wire        opt_lvr_en,      // Option: low_voltage_reset selected.
	input  wire        opt_long_delay,  // Option: long reset delay selected.
	input  wire        illegal_op,      // Decoder pulse: illegal opcode or prefix.
	output reg         sys_reset,       // Internal reset request to the core.
	output reg         rst_pin_o,       // Reset pin output level.
	output reg         rst_pin_oe,      // Reset pin output enable.
	output reg         irq              // Level interrupt.
);

	// ****************************************
	// Helpers
	// ****************************************
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	function [`SMRI_CNT_W-1:0] dly_limit;
		input long_sel;
		begin
			if (long_sel) begin
				dly_limit = DLY_LONG[`SMRI_CNT_W-1:0] - 1'b1;
			end else begin
				dly_limit = DLY_SHORT[`SMRI_CNT_W-1:0] - 1'b1;
			end
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg                    irq_en_q;
	reg                    irq_en_prev_q;
	reg                    flag_q;
	reg                    delay_run_q;
	reg  [`SMRI_CNT_W-1:0] dly_cnt_q;
	reg  [`SMRI_EV_W-1:0]  ev_q;
	reg  [`SMRI_EV_W-1:0]  ev_d;
	reg  [`SMRI_EV_W-1:0]  mask_q;
	reg                    illegal_q;

	wire                   setup_ph;
	wire                   wr_acc;
	wire                   supply_rst;
	wire                   flag_d;
	wire                   flag_tog;
	wire                   en_rise;
	wire                   aux_ev;
	wire                   start_dly;
	wire [`SMRI_EV_W-1:0]  set_ev;
	wire [`SMRI_EV_W-1:0]  clr_ev;
	wire                   mapped;

	// ****************************************
	// APB slave
	// ****************************************
	// The answer is prepared in the setup cycle, so every access completes in the
	// first access cycle with pready taken straight from a flip-flop.
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pready & pwrite;
	assign mapped   = hit(paddr, `SMRI_OFF_CTRL) | hit(paddr, `SMRI_OFF_STATUS) |
	                  hit(paddr, `SMRI_OFF_IRQ_STAT) | hit(paddr, `SMRI_OFF_IRQ_MASK);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `SMRI_DATA_RST;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata  <= `SMRI_DATA_RST;
			if (setup_ph && !pwrite) begin
				if (hit(paddr, `SMRI_OFF_CTRL)) begin
					prdata[`SMRI_CTRL_IRQ_EN] <= irq_en_q;
				end
				if (hit(paddr, `SMRI_OFF_STATUS)) begin
					prdata[`SMRI_ST_FLAG]  <= flag_q;
					prdata[`SMRI_ST_LOW]   <= supply_rst;
					prdata[`SMRI_ST_DELAY] <= delay_run_q;
					prdata[`SMRI_ST_OPT]   <= opt_lvr_en;
				end
				if (hit(paddr, `SMRI_OFF_IRQ_STAT)) begin
					prdata[`SMRI_EV_W-1:0] <= ev_q;
				end
				if (hit(paddr, `SMRI_OFF_IRQ_MASK)) begin
					prdata[`SMRI_EV_W-1:0] <= mask_q;
				end
			end
		end
	end

	// ****************************************
	// Control and mask registers
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q      <= `SMRI_CTRL_RST;
			irq_en_prev_q <= `SMRI_CTRL_RST;
			mask_q        <= `SMRI_EV_RST;
		end else begin
			irq_en_prev_q <= irq_en_q;
			if (wr_acc && hit(paddr, `SMRI_OFF_CTRL)) begin
				irq_en_q <= pwdata[`SMRI_CTRL_IRQ_EN];
			end
			if (wr_acc && hit(paddr, `SMRI_OFF_IRQ_MASK)) begin
				mask_q <= pwdata[`SMRI_EV_W-1:0];
			end
		end
	end

	// ****************************************
	// Supply reset and reset delay
	// ****************************************
	// Without the option the comparator is ignored entirely.
	assign supply_rst = opt_lvr_en & supply_low;

	// The delay restarts while any reset source is active, so it is timed from
	// the last moment a source was seen.
	assign start_dly = supply_rst | illegal_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_run_q <= 1'b1;
			dly_cnt_q   <= {`SMRI_CNT_W{1'b0}};
		end else if (start_dly) begin
			delay_run_q <= 1'b1;
			dly_cnt_q   <= {`SMRI_CNT_W{1'b0}};
		end else if (delay_run_q) begin
			if (dly_cnt_q == dly_limit(opt_long_delay)) begin
				delay_run_q <= 1'b0;
			end
			dly_cnt_q <= dly_cnt_q + 1'b1;
		end
	end

	// ****************************************
	// Illegal opcode capture
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= illegal_op;
		end
	end

	// ****************************************
	// Reset outputs
	// ****************************************
	// The pin is open drain: it only ever pulls low, and the enable shows when.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset  <= 1'b1;
			rst_pin_o  <= 1'b0;
			rst_pin_oe <= 1'b1;
		end else begin
			sys_reset  <= start_dly | delay_run_q;
			rst_pin_o  <= 1'b0;
			rst_pin_oe <= start_dly | delay_run_q;
		end
	end

	// ****************************************
	// Auxiliary warning flag and events
	// ****************************************
	assign flag_d   = opt_lvr_en & aux_cmp;
	assign flag_tog = flag_d ^ flag_q;

	// Toggles inside the reset delay are dropped rather than held back, which
	// is what keeps a fast supply ramp from leaving a stale interrupt.
	assign en_rise = irq_en_q & ~irq_en_prev_q & opt_lvr_en;
	assign aux_ev  = (flag_tog & irq_en_q & ~delay_run_q) | en_rise;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ****************************************
	// Interrupt status, write one to clear
	// ****************************************
	assign set_ev = {illegal_q, supply_rst, aux_ev};
	assign clr_ev = (wr_acc && hit(paddr, `SMRI_OFF_IRQ_STAT)) ?
	                pwdata[`SMRI_EV_W-1:0] : `SMRI_EV_RST;

	always @* begin
		// A new event in the clearing cycle survives the clear.
		ev_d = (ev_q & ~clr_ev) | set_ev;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_q <= `SMRI_EV_RST;
			irq  <= 1'b0;
		end else begin
			ev_q <= ev_d;
			irq  <= |(ev_d & mask_q);
		end
	end

endmodule

// [tb/smri_top_assertions.sv]
// Port checker for the supply monitor block.
`timescale 1ns/10ps
module smri_top_assertions #(
	parameter DLY_SHORT = 4,
	parameter DLY_LONG  = 8
) (
	input wire        pclk, presetn, psel, penable, pready, pslverr,
	input wire [31:0] prdata,
	input wire        supply_low, opt_lvr_en, illegal_op, sys_reset, rst_pin_o, rst_pin_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Reset hold counter
	// ****************************************
	// Counts reset cycles with no source, so a stuck reset is caught in bounded time.
	reg  [13:0] hold_q;
	wire        src = (supply_low & opt_lvr_en) | illegal_op;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_q <= 14'h0;
		else if (!sys_reset || src)
			hold_q <= 14'h0;
		else
			hold_q <= hold_q + 14'h1;
	end
	sequence setup_s; psel && !penable; endsequence
	sequence low_s; supply_low && opt_lvr_en; endsequence
	a_low_reset: assert property (low_s |=> sys_reset)
		else $error("reset not raised on low supply");
	a_pin_follow: assert property (rst_pin_oe == sys_reset && !rst_pin_o)
		else $error("reset pin not driven low with reset");
	a_illegal_rst: assert property (illegal_op |-> ##[1:2] sys_reset)
		else $error("no reset after illegal opcode");
	a_reset_ends: assert property (hold_q <= DLY_LONG + 4)
		else $error("reset held past the delay");
	a_no_source: assert property (!opt_lvr_en && !illegal_op && !$past(illegal_op)
		&& !sys_reset |=> !sys_reset)
		else $error("reset without a source");
	a_ready_one: assert property (setup_s |=> pready ##1 !pready)
		else $error("ready not a single access pulse");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response with data");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
endmodule

// [tb/test_supply_monitor_reset_irq.sv]
// Self-checking bench for the supply monitor block.
`timescale 1ns/10ps
`include "smri_defines.vh"
module test_supply_monitor_reset_irq;
	reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg         supply_low = 0, aux_cmp = 0, opt_lvr_en = 1, opt_long_delay = 0, illegal_op = 0;
	reg  [7:0]  paddr = 8'h0;
	reg  [31:0] pwdata = 32'h0, rd, rs = 32'h2b;
	wire [31:0] prdata;
	wire        pready, pslverr, sys_reset, rst_pin_o, rst_pin_oe, irq;
	integer     num_errors = 0, total_checks = 0, n, i;
	always #5 pclk = ~pclk;
	smri_top #(.DLY_SHORT(4), .DLY_LONG(8)) smri_top_inst (.*);
	function [31:0] xs(input [31:0] x); begin
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	end endfunction
	task tally_and_finish; begin
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end endtask
	task chk(input [31:0] g, input [31:0] e, input string m); begin
		total_checks = total_checks + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("MISMATCH %0t %0s", $time, m);
		end
	end endtask
	task w(input integer k); repeat (k) @(posedge pclk); endtask
	// Holds the request until ready is seen at an edge, then releases it.
	task apb(input w_, input [7:0] a, input [31:0] d); begin
		@(posedge pclk);
		psel <= 1; pwrite <= w_; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		chk(pslverr, a > 8'h0c, "slverr");
		psel <= 0; penable <= 0;
	end endtask
	task rdc(input [7:0] a, input [31:0] e, input string m); begin
		apb(0, a, 32'h0);
		chk(rd, e, m);
	end endtask
	task clr; apb(1, `SMRI_OFF_IRQ_STAT, 32'h7); endtask
	task wrel(input integer lim); begin
		n = 0;
		while (sys_reset !== 1'b0 && n < 50) begin @(posedge pclk); n = n + 1; end
		chk(n >= lim - 2 && n <= lim + 4, 1, "delay");
	end endtask
	initial begin
		w(10);
		chk(sys_reset & rst_pin_oe & !rst_pin_o, 1, "rst");
		presetn <= 1;
		wrel(4);
		rdc(`SMRI_OFF_CTRL, 0, "ctrl");
		rdc(`SMRI_OFF_IRQ_MASK, 0, "mask");
		rdc(8'h10, 0, "unmap");
		rs = xs(rs);
		apb(1, `SMRI_OFF_IRQ_MASK, rs);
		rdc(`SMRI_OFF_IRQ_MASK, rs & 7, "mask rw");
		apb(1, `SMRI_OFF_IRQ_MASK, 7);
		clr;
		aux_cmp <= 1;
		w(3);
		apb(1, `SMRI_OFF_STATUS, 0);
		rdc(`SMRI_OFF_STATUS, 32'h9, "flag");
		rdc(`SMRI_OFF_IRQ_STAT, 0, "no ev");
		rs = xs(rs);
		apb(1, `SMRI_OFF_CTRL, rs | 1);
		w(4);
		chk(irq, 1, "irq en");
		rdc(`SMRI_OFF_IRQ_STAT, 1, "ev en");
		clr;
		w(3);
		chk(irq, 0, "irq clr");
		for (i = 0; i < 2; i = i + 1) begin
			aux_cmp <= !aux_cmp;
			w(4);
			chk(irq, 1, "irq tog");
			rdc(`SMRI_OFF_IRQ_STAT, 1, "ev tog");
			clr;
		end
		apb(1, `SMRI_OFF_IRQ_MASK, 0);
		aux_cmp <= 0;
		w(4);
		chk(irq, 0, "masked");
		apb(1, `SMRI_OFF_IRQ_MASK, 7);
		w(3);
		chk(irq, 1, "unmask");
		apb(1, `SMRI_OFF_CTRL, 0);
		clr;
		apb(1, `SMRI_OFF_CTRL, 1);
		w(4);
		rdc(`SMRI_OFF_IRQ_STAT, 1, "one");
		clr;
		w(8);
		rdc(`SMRI_OFF_IRQ_STAT, 0, "only one");
		supply_low <= 1;
		w(2);
		aux_cmp <= 1;
		w(1);
		supply_low <= 0;
		chk(rst_pin_oe, 1, "pin");
		wrel(4);
		rdc(`SMRI_OFF_IRQ_STAT, 2, "drop");
		clr;
		opt_long_delay <= 1;
		illegal_op <= 1;
		w(1);
		illegal_op <= 0;
		w(2);
		chk(sys_reset, 1, "illegal");
		wrel(8);
		rdc(`SMRI_OFF_IRQ_STAT, 4, "ill ev");
		aux_cmp <= 0;
		w(3);
		clr;
		opt_lvr_en <= 0;
		supply_low <= 1;
		aux_cmp <= 1;
		w(5);
		chk(sys_reset, 0, "opt off");
		rdc(`SMRI_OFF_STATUS, 0, "opt flag");
		rdc(`SMRI_OFF_IRQ_STAT, 0, "opt ev");
		tally_and_finish;
	end
	initial begin
		#100000;
		num_errors = num_errors + 1;
		tally_and_finish;
	end
endmodule
bind smri_top smri_top_assertions #(.DLY_SHORT(DLY_SHORT), .DLY_LONG(DLY_LONG))
	smri_top_assertions_inst (.*);
